// ==== design/cmf_pkg.sv ====
// shared constants and types for the cache miss and line-fill block
package cmf_pkg;

  // control register codes on the move-to-control port
  localparam logic [11:0] CODE_CACHE_CTL = 12'h002;
  localparam logic [11:0] CODE_ACC_CTL0  = 12'h004;
  localparam logic [11:0] CODE_ACC_CTL1  = 12'h005;

  // reset values
  localparam logic [31:0] CACHE_CTL_RST  = 32'h0000_0000;
  localparam logic [31:0] ACC_CTL_RST    = 32'h0000_0000;

  // cache_control_register field positions
  localparam int CC_ENABLE    = 31;
  localparam int CC_FREEZE    = 27;
  localparam int CC_INVAL     = 24;
  localparam int CC_DIS_INSTR = 23;
  localparam int CC_DIS_DATA  = 22;
  localparam int CC_BUF_NC    = 10;
  localparam int CC_DEF_NC    = 9;
  localparam int CC_LNF_HI    = 1;
  localparam int CC_LNF_LO    = 0;
  // bits that store; invalidate_all_bit is an action and always reads zero
  localparam logic [31:0] CACHE_CTL_WMASK = 32'h88C0_0603;

  // access control register field positions
  localparam int AC_BASE_HI   = 31;
  localparam int AC_BASE_LO   = 24;
  localparam int AC_MASK_HI   = 23;
  localparam int AC_MASK_LO   = 16;
  localparam int AC_ENABLE    = 15;
  localparam int AC_NC        = 6;

  // array geometry
  localparam int IDX_W        = 10;
  localparam int TAG_W        = 19;
  localparam int LINES        = 1024;
  localparam int WORDS        = 4096;
  localparam logic [IDX_W-1:0] INV_LAST = 10'h3FF;
  localparam logic [1:0]  LW_LAST     = 2'h3;

  // external fetch size codes
  localparam logic [1:0]  SIZE_WORD   = 2'h1;
  localparam logic [1:0]  SIZE_LONG   = 2'h2;
  localparam logic [1:0]  SIZE_LINE   = 2'h3;

  // main sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INVAL,
    ST_WBACK,
    ST_FETCH
  } cmf_state_e;

  // line-fill buffer status
  typedef struct packed {
    logic [27:0] line;
    logic [3:0]  lw_valid;
    logic        mru;
    logic        nc;
  } cmf_lfb_s;

  // one external fetch request
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  size;
  } cmf_ext_s;

endpackage : cmf_pkg

// ==== design/cmf_line_buf.sv ====
// one 16-byte line-fill buffer with per-longword valid and recency flag
`timescale 1ns/1ps
module cmf_line_buf (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // new line
  input  wire logic             start,
  input  wire logic [27:0]      start_line,
  input  wire logic             start_nc,
  // arriving longword
  input  wire logic             load,
  input  wire logic [1:0]       load_lw,
  input  wire logic [31:0]      load_data,
  // housekeeping
  input  wire logic             drop,
  input  wire logic             mru_clear,
  // contents
  output cmf_pkg::cmf_lfb_s     status,
  output logic      [127:0]     line_data
);
  import cmf_pkg::*;

  cmf_lfb_s st_q;

  // status flags; a new line always wins over a recency clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (drop) begin
      st_q.lw_valid <= 4'h0;
      st_q.mru      <= 1'b0;
    end else if (start) begin
      st_q.line     <= start_line;
      st_q.lw_valid <= 4'h0;
      st_q.nc       <= start_nc;
      st_q.mru      <= 1'b1;
    end else begin
      if (load) begin
        st_q.lw_valid[load_lw] <= 1'b1;
      end
      if (mru_clear) begin
        st_q.mru <= 1'b0;
      end
    end
  end

  // data storage needs no reset, valid bits guard it
  always_ff @(posedge clk) begin
    if (load) begin
      line_data[{load_lw, 5'h00} +: 32] <= load_data;
    end
  end

  assign status = st_q;

endmodule : cmf_line_buf

// ==== design/cmf_miss_fill.sv ====
// miss handling, line fill and control registers of a direct-mapped cache
`timescale 1ns/1ps
module cmf_miss_fill (
  // clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RST_N,
  // move-to-control register port
  input  wire logic             CTL_WR,
  input  wire logic             CTL_RD,
  input  wire logic [11:0]      CTL_CODE,
  input  wire logic [31:0]      CTL_WDATA,
  input  wire logic             CTL_SUPER,
  input  wire logic             CTL_DEBUG,
  output logic      [31:0]      CTL_RDATA,
  // core local bus
  input  wire logic             CORE_REQ,
  input  wire logic             CORE_INSTR,
  input  wire logic [31:0]      CORE_ADDR,
  output logic                  CORE_READY,
  output logic      [31:0]      CORE_RDATA,
  // external fetch path
  output logic                  EXT_REQ,
  output logic      [31:0]      EXT_ADDR,
  output logic      [1:0]       EXT_SIZE,
  input  wire logic             EXT_ACK,
  input  wire logic [31:0]      EXT_DATA
);
  import cmf_pkg::*;

  // array index: split mode puts the fetch type in the top bit
  function automatic logic [IDX_W-1:0] cmf_index(input logic [31:0] a, input logic instr, input logic split);
    cmf_index = split ? {instr, a[12:4]} : a[13:4];
  endfunction : cmf_index

  // tag compare width follows the configuration
  function automatic logic cmf_tag_hit(input logic [TAG_W-1:0] t, input logic [31:0] a, input logic split);
    cmf_tag_hit = split ? (t == a[31:13]) : (t[TAG_W-1:1] == a[31:14]);
  endfunction : cmf_tag_hit

  // access control match on masked upper address byte
  function automatic logic cmf_acc_hit(input logic [31:0] r, input logic [31:0] a);
    cmf_acc_hit = r[AC_ENABLE] &&
                  (((a[31:24] ^ r[AC_BASE_HI:AC_BASE_LO]) & ~r[AC_MASK_HI:AC_MASK_LO]) == 8'h00);
  endfunction : cmf_acc_hit

  // whole-line decision for instruction misses
  function automatic logic cmf_line_fetch(input logic [1:0] lnf, input logic [1:0] lw);
    if (lnf[1]) begin
      cmf_line_fetch = 1'b1;
    end else if (lnf[0]) begin
      cmf_line_fetch = !lw[1];
    end else begin
      cmf_line_fetch = (lw != LW_LAST);
    end
  endfunction : cmf_line_fetch

  cmf_state_e          state_q;
  logic [31:0]         cache_ctl_q;
  logic [31:0]         acc_ctl0_q;
  logic [31:0]         acc_ctl1_q;
  logic                inval_pend_q;
  logic [IDX_W-1:0]    cnt_q;
  // captured miss
  logic [31:0]         miss_addr_q;
  logic                miss_instr_q;
  logic                miss_buf_q;
  logic                miss_nc_q;
  logic [1:0]          miss_size_q;
  // fill in progress
  logic                fill_act_q;
  logic                fill_buf_q;
  logic                fill_sel_q;
  logic [1:0]          fcnt_q;
  cmf_ext_s            ext_q;
  logic                ext_req_q;
  logic                ready_q;
  logic [31:0]         rdata_q;
  logic [31:0]         ctl_rdata_q;
  // arrays, deliberately never reset
  logic [TAG_W-1:0]    tag_a   [0:LINES-1];
  logic                valid_a [0:LINES-1];
  logic [31:0]         data_a  [0:WORDS-1];
  // line-fill buffers, index 0 data and 1 instruction
  cmf_lfb_s            lfb_st   [0:1];
  logic [127:0]        lfb_data [0:1];
  logic [1:0]          lfb_start;
  logic [1:0]          lfb_load;
  logic [1:0]          lfb_mru_clr;
  logic [IDX_W-1:0]    lfb_idx  [0:1];

  // decoded control fields
  logic       cache_enable_bit, cfrz, disi, disd, buffer_noncacheable_instr_bit, def_nc, split;
  logic [1:0] line_fetch_size_field;
  assign cache_enable_bit   = cache_ctl_q[CC_ENABLE];
  assign cfrz   = cache_ctl_q[CC_FREEZE];
  assign disi   = cache_ctl_q[CC_DIS_INSTR];
  assign disd   = cache_ctl_q[CC_DIS_DATA];
  assign buffer_noncacheable_instr_bit   = cache_ctl_q[CC_BUF_NC];
  assign def_nc = cache_ctl_q[CC_DEF_NC];
  assign line_fetch_size_field   = cache_ctl_q[CC_LNF_HI:CC_LNF_LO];
  assign split  = !disi && !disd;

  // lookup of the current core request
  logic             take, noncache, cacheable, buffered, arr_hit, buf_hit, is_line, need_wb;
  logic [IDX_W-1:0] idx;
  logic [1:0]       lw;
  logic             sel;
  always_comb begin
    take     = CORE_REQ && !ready_q && (state_q == ST_IDLE) && !inval_pend_q;
    idx      = cmf_index(CORE_ADDR, CORE_INSTR, split);
    lw       = CORE_ADDR[3:2];
    sel      = CORE_INSTR;
    if (cmf_acc_hit(acc_ctl0_q, CORE_ADDR)) begin
      noncache = acc_ctl0_q[AC_NC];
    end else if (cmf_acc_hit(acc_ctl1_q, CORE_ADDR)) begin
      noncache = acc_ctl1_q[AC_NC];
    end else begin
      noncache = def_nc;
    end
    cacheable = cache_enable_bit && !noncache && (CORE_INSTR ? !disi : !disd);
    buffered  = cacheable || (cache_enable_bit && buffer_noncacheable_instr_bit && CORE_INSTR && noncache);
    arr_hit   = cacheable && valid_a[idx] && cmf_tag_hit(tag_a[idx], CORE_ADDR, split);
    buf_hit   = buffered && (lfb_st[sel].line == CORE_ADDR[31:4]) && lfb_st[sel].lw_valid[lw];
    is_line   = buffered && (!CORE_INSTR || cmf_line_fetch(line_fetch_size_field, lw));
    // write back only full, newest, cacheable contents
    need_wb   = (lfb_st[sel].lw_valid == 4'hF) && lfb_st[sel].mru && !lfb_st[sel].nc &&
                !(cfrz && valid_a[lfb_idx[sel]]) && !fill_act_q;
  end

  // control registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cache_ctl_q <= CACHE_CTL_RST;
      acc_ctl0_q  <= ACC_CTL_RST;
      acc_ctl1_q  <= ACC_CTL_RST;
    end else if (CTL_WR && CTL_SUPER) begin
      case (CTL_CODE)
        CODE_CACHE_CTL: cache_ctl_q <= CTL_WDATA & CACHE_CTL_WMASK;
        CODE_ACC_CTL0:  acc_ctl0_q  <= CTL_WDATA;
        CODE_ACC_CTL1:  acc_ctl1_q  <= CTL_WDATA;
        default:        ;
      endcase
    end
  end

  // invalidate request; a new request wins over the clear
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      inval_pend_q <= 1'b0;
    end else begin
      if (state_q == ST_INVAL) begin
        inval_pend_q <= 1'b0;
      end
      if (CTL_WR && CTL_SUPER && (CTL_CODE == CODE_CACHE_CTL) && CTL_WDATA[CC_INVAL]) begin
        inval_pend_q <= 1'b1;
      end
    end
  end

  // read-back port
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_rdata_q <= 32'h0000_0000;
    end else if (CTL_RD) begin
      if (CTL_DEBUG && (CTL_CODE == CODE_CACHE_CTL)) begin
        ctl_rdata_q <= cache_ctl_q;
      end else begin
        ctl_rdata_q <= 32'h0000_0000;
      end
    end
  end

  // sequencer and core answer
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q      <= ST_IDLE;
      cnt_q        <= '0;
      ready_q      <= 1'b0;
      rdata_q      <= 32'h0000_0000;
      miss_addr_q  <= 32'h0000_0000;
      miss_instr_q <= 1'b0;
      miss_buf_q   <= 1'b0;
      miss_nc_q    <= 1'b0;
      miss_size_q  <= SIZE_LONG;
    end else begin
      ready_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          // fetches wait while the sweep is pending
          if (inval_pend_q && !fill_act_q) begin
            state_q <= ST_INVAL;
          end else if (take && buf_hit) begin
            ready_q <= 1'b1;
            rdata_q <= lfb_data[sel][{lw, 5'h00} +: 32];
          end else if (take && arr_hit) begin
            ready_q <= 1'b1;
            rdata_q <= data_a[{idx, lw}];
          end else if (take && !fill_act_q) begin
            miss_addr_q  <= CORE_ADDR;
            miss_instr_q <= CORE_INSTR;
            miss_buf_q   <= buffered;
            miss_nc_q    <= !cacheable;
            if (is_line) begin
              miss_size_q <= SIZE_LINE;
            end else if (!buffered && CORE_INSTR && CORE_ADDR[1]) begin
              miss_size_q <= SIZE_WORD;
            end else begin
              miss_size_q <= SIZE_LONG;
            end
            state_q <= need_wb ? ST_WBACK : ST_FETCH;
          end
        end
        ST_INVAL: begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q == INV_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        ST_WBACK: begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q[1:0] == LW_LAST) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // critical longword releases the core, rest fills behind
          if (fill_act_q && EXT_ACK && (fcnt_q == 2'h0)) begin
            ready_q <= 1'b1;
            rdata_q <= EXT_DATA;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // external fetch and buffer loading
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fill_act_q <= 1'b0;
      fill_buf_q <= 1'b0;
      fill_sel_q <= 1'b0;
      fcnt_q     <= 2'h0;
      ext_q      <= '0;
      ext_req_q  <= 1'b0;
    end else if ((state_q == ST_FETCH) && !fill_act_q) begin
      fill_act_q <= 1'b1;
      fill_buf_q <= miss_buf_q;
      fill_sel_q <= miss_instr_q;
      fcnt_q     <= 2'h0;
      ext_req_q  <= 1'b1;
      ext_q.size <= miss_size_q;
      ext_q.addr <= (miss_size_q == SIZE_WORD) ? {miss_addr_q[31:1], 1'b0} : {miss_addr_q[31:2], 2'b00};
    end else if (fill_act_q && EXT_ACK) begin
      if ((ext_q.size != SIZE_LINE) || (fcnt_q == LW_LAST)) begin
        fill_act_q <= 1'b0;
        ext_req_q  <= 1'b0;
      end else begin
        fcnt_q <= fcnt_q + 2'h1;
        ext_q.addr[3:2] <= ext_q.addr[3:2] + 2'h1;
      end
    end
  end

  // array updates; no reset keeps stale tags after reset
  // arrays untouched by reset
  always_ff @(posedge REF_CLK) begin
    if (state_q == ST_INVAL) begin
      valid_a[cnt_q] <= 1'b0;
    end else if (state_q == ST_WBACK) begin
      data_a[{lfb_idx[miss_instr_q], cnt_q[1:0]}] <= lfb_data[miss_instr_q][{cnt_q[1:0], 5'h00} +: 32];
      if (cnt_q[1:0] == 2'h0) begin
        tag_a[lfb_idx[miss_instr_q]]   <= lfb_st[miss_instr_q].line[27:9];
        valid_a[lfb_idx[miss_instr_q]] <= 1'b1;
      end
    end
  end

  // two fill buffers, instruction and data
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lfb
      assign lfb_idx[g]     = cmf_index({lfb_st[g].line, 4'h0}, g[0], split);
      assign lfb_start[g]   = (state_q == ST_FETCH) && !fill_act_q && miss_buf_q && (miss_instr_q == g[0]);
      assign lfb_load[g]    = fill_act_q && EXT_ACK && fill_buf_q && (fill_sel_q == g[0]);
      assign lfb_mru_clr[g] = (take && arr_hit && (idx == lfb_idx[g])) ||
                              ((state_q == ST_WBACK) && (miss_instr_q == g[0]));
      cmf_line_buf u_buf (
        .clk        (REF_CLK),
        .rst_n      (RST_N),
        .start      (lfb_start[g]),
        .start_line (miss_addr_q[31:4]),
        .start_nc   (miss_nc_q),
        .load       (lfb_load[g]),
        .load_lw    (ext_q.addr[3:2]),
        .load_data  (EXT_DATA),
        .drop       (state_q == ST_INVAL),
        .mru_clear  (lfb_mru_clr[g]),
        .status     (lfb_st[g]),
        .line_data  (lfb_data[g])
      );
    end
  endgenerate

  // outputs straight from flip-flops
  assign CTL_RDATA  = ctl_rdata_q;
  assign CORE_READY = ready_q;
  assign CORE_RDATA = rdata_q;
  assign EXT_REQ    = ext_req_q;
  assign EXT_ADDR   = ext_q.addr;
  assign EXT_SIZE   = ext_q.size;

endmodule : cmf_miss_fill

// ==== bench/cmf_miss_fill_chk.sv ====
// port-level assertion checker for the cache miss and line-fill block
`timescale 1ns/1ps
module cmf_miss_fill_chk
  import cmf_pkg::*;
(
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  // control port
  input wire logic        CTL_RD,
  input wire logic [11:0] CTL_CODE,
  input wire logic        CTL_DEBUG,
  input wire logic [31:0] CTL_RDATA,
  // core bus
  input wire logic        CORE_REQ,
  input wire logic        CORE_READY,
  // external fetch path
  input wire logic        EXT_REQ,
  input wire logic [31:0] EXT_ADDR,
  input wire logic [1:0]  EXT_SIZE,
  input wire logic        EXT_ACK
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // acks taken so far in the running external fetch
  logic [1:0]  ack_cnt_q;
  logic [31:0] wrap_d;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) ack_cnt_q <= 2'h0;
    else if (!EXT_REQ) ack_cnt_q <= 2'h0;
    else if (EXT_ACK) ack_cnt_q <= ack_cnt_q + 2'h1;
  end
  // next longword of a line, wrapping inside the 16 bytes
  assign wrap_d = {EXT_ADDR[31:4], EXT_ADDR[3:2] + 2'h1, 2'h0};

  sequence s_first_ack;
    EXT_REQ && EXT_ACK && ack_cnt_q == 2'h0 && CORE_REQ;
  endsequence
  sequence s_last_line_ack;
    EXT_REQ && EXT_ACK && EXT_SIZE == SIZE_LINE && ack_cnt_q == 2'h3;
  endsequence

  a_reset_idle: assert property ($rose(RST_N) |-> !EXT_REQ && !CORE_READY && CTL_RDATA == 32'h0)
    else $error("outputs not clear after reset");
  a_ready_after_ack: assert property (s_first_ack |=> CORE_READY ##1 !CORE_READY)
    else $error("core answer not one cycle after first longword");
  a_line_wrap: assert property (EXT_ACK && EXT_SIZE == SIZE_LINE && ack_cnt_q != 2'h3 |=> EXT_ADDR == $past(wrap_d))
    else $error("line fetch address did not wrap by one longword");
  a_line_ends: assert property (s_last_line_ack |=> !EXT_REQ)
    else $error("line fetch not ended after four longwords");
  a_single_ends: assert property (EXT_REQ && EXT_ACK && EXT_SIZE != SIZE_LINE |=> !EXT_REQ)
    else $error("single fetch not ended after one ack");
  // word fetch only at odd word
  a_word_odd: assert property ($rose(EXT_REQ) && EXT_SIZE == SIZE_WORD |-> EXT_ADDR[1])
    else $error("word fetch at even word address");
  a_rd_gated: assert property (CTL_RD && !(CTL_DEBUG && CTL_CODE == CODE_CACHE_CTL) |=> CTL_RDATA == 32'h0)
    else $error("control read returned data outside debug cache read");
  a_rd_masked: assert property (CTL_RD |=> (CTL_RDATA & ~CACHE_CTL_WMASK) == 32'h0)
    else $error("reserved control bits read nonzero");
endmodule : cmf_miss_fill_chk

// ==== bench/cmf_ext_mem.sv ====
// external memory model answering line, longword and word fetches
`timescale 1ns/1ps
module cmf_ext_mem (
  // clock
  input  wire logic        clk,
  // fetch request from the block
  input  wire logic        ext_req,
  input  wire logic [31:0] ext_addr,
  // answer pacing, 0 prompt to 3 slow
  input  wire logic [1:0]  slow,
  // answer
  output logic             ext_ack,
  output logic      [31:0] ext_data
);
  logic [2:0] wait_q = 3'h0;
  initial begin
    ext_ack = 1'b0;
    ext_data = 32'h0;
  end
  // at least one idle cycle between acks so a stale address is never answered
  always @(posedge clk) begin
    if (ext_ack || !ext_req) begin
      ext_ack  <= 1'b0;
      wait_q   <= 3'h0;
      ext_data <= ~ext_data;
    end else if (wait_q > {1'b0, slow}) begin
      ext_ack  <= 1'b1;
      ext_data <= {ext_addr[31:2], 2'h0} ^ 32'h5A5A_C3C3;
    end else begin
      wait_q   <= wait_q + 3'h1;
      ext_data <= ~ext_data;
    end
  end
endmodule : cmf_ext_mem

// ==== bench/cmf_miss_fill_bench.sv ====
// self-checking bench for the cache miss and line-fill block
`timescale 1ns/1ps
module cmf_miss_fill_bench;
  import cmf_pkg::*;
  logic        REF_CLK    = 1'b0;
  logic        RST_N      = 1'b0;
  logic        CTL_WR     = 1'b0;
  logic        CTL_RD     = 1'b0;
  logic [11:0] CTL_CODE   = 12'h0;
  logic [31:0] CTL_WDATA  = 32'h0;
  logic        CTL_SUPER  = 1'b0;
  logic        CTL_DEBUG  = 1'b0;
  logic        CORE_REQ   = 1'b0;
  logic        CORE_INSTR = 1'b0;
  logic [31:0] CORE_ADDR  = 32'h0;
  logic [1:0]  slow       = 2'h0;
  logic [31:0] CTL_RDATA, CORE_RDATA, EXT_ADDR, EXT_DATA;
  logic        CORE_READY, EXT_REQ, EXT_ACK;
  logic [1:0]  EXT_SIZE;
  logic [33:0] acks[$];
  int          bad_count   = 0;
  int          comparisons = 0;

  always #2.5 REF_CLK = ~REF_CLK;

  cmf_miss_fill u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CTL_WR(CTL_WR), .CTL_RD(CTL_RD),
    .CTL_CODE(CTL_CODE), .CTL_WDATA(CTL_WDATA), .CTL_SUPER(CTL_SUPER), .CTL_DEBUG(CTL_DEBUG),
    .CTL_RDATA(CTL_RDATA), .CORE_REQ(CORE_REQ), .CORE_INSTR(CORE_INSTR), .CORE_ADDR(CORE_ADDR),
    .CORE_READY(CORE_READY), .CORE_RDATA(CORE_RDATA), .EXT_REQ(EXT_REQ), .EXT_ADDR(EXT_ADDR),
    .EXT_SIZE(EXT_SIZE), .EXT_ACK(EXT_ACK), .EXT_DATA(EXT_DATA));
  cmf_ext_mem u_mem (.clk(REF_CLK), .ext_req(EXT_REQ), .ext_addr(EXT_ADDR), .slow(slow),
    .ext_ack(EXT_ACK), .ext_data(EXT_DATA));

  // every delivered longword with its size, in arrival order
  always @(posedge REF_CLK)
    if (EXT_REQ === 1'b1 && EXT_ACK === 1'b1) acks.push_back({EXT_SIZE, EXT_ADDR});

  function automatic logic [31:0] mem(input logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'h5A5A_C3C3;
  endfunction : mem
  // instruction miss size from line-fetch field and longword offset
  function automatic logic [1:0] isize(input logic [1:0] f, input logic [1:0] o);
    if (f[1] || o < 2'h2 || (f == 2'h0 && o == 2'h2)) return SIZE_LINE;
    return SIZE_LONG;
  endfunction : isize
  function automatic logic [33:0] exp_ack(input logic [1:0] sz, input logic [31:0] a, input int k);
    if (sz == SIZE_LINE) return {sz, a[31:4], a[3:2] + 2'(k), 2'h0};
    if (sz == SIZE_WORD) return {sz, a};
    return {sz, a[31:2], 2'h0};
  endfunction : exp_ack

  task automatic fail(input string m);
    bad_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : fail
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask : cmp_word
  task automatic cmp_ack(input logic [33:0] g, input logic [33:0] e);
    comparisons++;
    if (g !== e) fail("external fetch order or size");
  endtask : cmp_ack

  task automatic ctl_wr(input logic [11:0] c, input logic [31:0] d, input logic s);
    CTL_WR    <= 1'b1;
    CTL_CODE  <= c;
    CTL_WDATA <= d;
    CTL_SUPER <= s;
    @(posedge REF_CLK);
    CTL_WR <= 1'b0;
    @(posedge REF_CLK);
  endtask : ctl_wr
  task automatic ctl_rd(input logic [11:0] c, input logic dbg, input logic [31:0] e);
    CTL_RD    <= 1'b1;
    CTL_CODE  <= c;
    CTL_DEBUG <= dbg;
    @(posedge REF_CLK);
    CTL_RD <= 1'b0;
    @(posedge REF_CLK);
    cmp_word(CTL_RDATA, e, "control readback");
  endtask : ctl_rd
  // one core fetch; sz 0 means no external fetch is expected
  task automatic fetch(input logic i, input logic [31:0] a, input logic [1:0] sz);
    int n;
    n = 0;
    acks.delete();
    slow       <= 2'($urandom_range(3, 0));
    CORE_REQ   <= 1'b1;
    CORE_INSTR <= i;
    CORE_ADDR  <= a;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (CORE_READY !== 1'b1 && n < 3000);
    CORE_REQ <= 1'b0;
    cmp_word(CORE_RDATA, mem(a), "core read data");
    // let an edge pass so the next request never retakes the strobe in the same step
    do begin
      @(posedge REF_CLK);
      n++;
    end while (EXT_REQ !== 1'b0 && n < 3000);
    if (n >= 3000) fail("fetch timed out");
    cmp_word(32'(acks.size()), sz == SIZE_LINE ? 32'h4 : 32'(sz != 2'h0), "external ack count");
    foreach (acks[k]) cmp_ack(acks[k], exp_ack(sz, a, k));
  endtask : fetch

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // hang guard, far beyond the sweep plus all fetches
  initial begin
    repeat (40000) @(posedge REF_CLK);
    fail("watchdog expired");
    conclude();
  end

  initial begin
    logic [31:0] a;
    logic [31:0] prev;
    void'($urandom(32'h5C11_1101));
    repeat (10) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    // registers clear, user writes and odd codes dropped
    ctl_rd(CODE_CACHE_CTL, 1'b1, 32'h0);
    ctl_wr(CODE_CACHE_CTL, CACHE_CTL_WMASK, 1'b0);
    ctl_rd(CODE_CACHE_CTL, 1'b1, 32'h0);
    ctl_wr(CODE_CACHE_CTL, ~CACHE_CTL_WMASK, 1'b1);
    ctl_rd(CODE_CACHE_CTL, 1'b1, 32'h0);
    ctl_wr(CODE_ACC_CTL0, 32'h1000_8000, 1'b1);
    ctl_rd(CODE_ACC_CTL0, 1'b1, 32'h0);
    ctl_wr(12'h003, 32'hFFFF_FFFF, 1'b1);
    ctl_rd(12'h003, 1'b1, 32'h0);
    ctl_wr(CODE_ACC_CTL1, 32'h0, 1'b1);
    ctl_wr(CODE_CACHE_CTL, 32'h8000_0000, 1'b1);
    ctl_rd(CODE_CACHE_CTL, 1'b0, 32'h0);
    ctl_rd(CODE_CACHE_CTL, 1'b1, 32'h8000_0000);
    // data misses, buffer hits, and written-back lines hitting the array
    prev = 32'h0;
    for (int k = 0; k < 8; k++) begin
      a = 32'h2000_0000 | (k << 14) | (k << 4) | ($urandom & 32'h1F8C);
      fetch(1'b0, a, SIZE_LINE);
      fetch(1'b0, a ^ 32'h8, 2'h0);
      if (k > 0) fetch(1'b0, prev, 2'h0);
      prev = a;
    end
    // array hit at the buffer's index makes the buffer stale
    fetch(1'b0, 32'h2100_0040, SIZE_LINE);
    fetch(1'b0, 32'h2100_0080, SIZE_LINE);
    fetch(1'b0, 32'h2104_0040, SIZE_LINE);
    fetch(1'b0, 32'h2100_0040, 2'h0);
    fetch(1'b0, 32'h2100_00C0, SIZE_LINE);
    fetch(1'b0, 32'h2100_0040, 2'h0);
    // instruction miss size for every line-fetch value and offset
    for (int f = 0; f < 4; f++) begin
      ctl_wr(CODE_CACHE_CTL, 32'h8000_0000 | f, 1'b1);
      for (int o = 0; o < 4; o++) begin
        a = 32'h3000_0000 | (f << 16) | (o << 14) | (o << 2) | ($urandom & 32'h1FF0);
        fetch(1'b1, a, isize(2'(f), 2'(o)));
      end
    end
    // default noncacheable, buffered, then unbuffered
    ctl_wr(CODE_CACHE_CTL, 32'h8000_0600, 1'b1);
    fetch(1'b1, 32'h4000_0104, SIZE_LINE);
    fetch(1'b1, 32'h4000_0108, 2'h0);
    fetch(1'b1, 32'h3800_0200, SIZE_LINE);
    fetch(1'b1, 32'h4000_0104, SIZE_LINE);
    ctl_wr(CODE_CACHE_CTL, 32'h8000_0200, 1'b1);
    fetch(1'b1, 32'h1000_0200, SIZE_LINE);
    fetch(1'b1, 32'h4000_0300, SIZE_LONG);
    fetch(1'b1, 32'h4000_0302, SIZE_WORD);
    // second reset mid-run, then cache off with both buffering settings
    RST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    ctl_rd(CODE_CACHE_CTL, 1'b1, 32'h0);
    for (int b = 0; b < 2; b++) begin
      ctl_wr(CODE_CACHE_CTL, 32'(b) << CC_BUF_NC, 1'b1);
      fetch(1'b1, 32'h3000_0000, SIZE_LONG);
      fetch(1'b1, 32'h3000_0006, SIZE_WORD);
    end
    // arrays outlive reset, and the buffered noncacheable line never reached them
    ctl_wr(CODE_CACHE_CTL, 32'h8000_0000, 1'b1);
    fetch(1'b0, 32'h2100_0040, 2'h0);
    fetch(1'b1, 32'h4000_0104, SIZE_LINE);
    conclude();
  end
endmodule : cmf_miss_fill_bench

bind cmf_miss_fill cmf_miss_fill_chk u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .CTL_RD(CTL_RD),
  .CTL_CODE(CTL_CODE), .CTL_DEBUG(CTL_DEBUG), .CTL_RDATA(CTL_RDATA), .CORE_REQ(CORE_REQ),
  .CORE_READY(CORE_READY), .EXT_REQ(EXT_REQ), .EXT_ADDR(EXT_ADDR), .EXT_SIZE(EXT_SIZE), .EXT_ACK(EXT_ACK));
